// >>> tmr_pkg.sv
// package for the timer0 block with the shared prescaler
package tmr_pkg;
   // register word offsets, byte addresses
   localparam logic [3:0] TMR_ADDR_COUNT = 4'h0;
   localparam logic [3:0] TMR_ADDR_OPTION = 4'h4;
   localparam logic [3:0] TMR_ADDR_INTCTL = 4'h8;
   localparam logic [3:0] TMR_ADDR_STATUS = 4'hC;
   localparam logic [3:0] TMR_ADDR_INT_EN = 4'h0;
   // extra registers
   localparam logic [4:0] TMR_ADDR_IRQ_STAT = 5'h10;
   localparam logic [4:0] TMR_ADDR_IRQ_EN = 5'h14;
   localparam logic [4:0] TMR_ADDR_IRQ_CLR = 5'h18;
   localparam logic [4:0] TMR_ADDR_WDT_CLR = 5'h1C;
   localparam logic [4:0] TMR_ADDR_CNT = 5'h00;
   localparam logic [4:0] TMR_ADDR_OPT = 5'h04;
   localparam logic [4:0] TMR_ADDR_ICTL = 5'h08;
   localparam logic [4:0] TMR_ADDR_WDT = 5'h0C;
   // option register fields
   localparam int TMR_OPT_CS = 5;
   localparam int TMR_OPT_SE = 4;
   localparam int TMR_OPT_PSA = 3;
   localparam int TMR_OPT_PS_LO = 0;
   // interrupt control field
   localparam int TMR_ICTL_OVF = 2;
   localparam int TMR_ICTL_OVF_EN = 5;
   // reset values
   localparam logic [7:0] TMR_OPT_RST = 8'hFF;
   localparam logic [7:0] TMR_ICTL_RST = 8'h00;
   localparam logic [7:0] TMR_CNT_RST = 8'h00;
   // instruction cycle is four phases
   localparam logic [1:0] TMR_PHASE_LAST = 2'h3;
   // irq event bits
   localparam int TMR_IRQ_OVF = 0;
   localparam int TMR_IRQ_WDT = 1;
   localparam int TMR_IRQ_W = 2;
   // watchdog count width
   localparam int TMR_WDT_W = 16;
   localparam logic [15:0] TMR_WDT_MAX = 16'hFFFF;

   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } tmr_avreq_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tmr_avrsp_s;
endpackage

// >>> tmr_prescaler.sv
// shared 8-bit prescaler, timer or watchdog side
`timescale 1ns/1ps
module tmr_prescaler
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic clr,
   input wire logic tick,
   input wire logic [2:0] rate,
   input wire logic to_wdt,
   // output
   output logic out_tick
);
   import tmr_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic out;
   } tmr_ps_s;

   tmr_ps_s st_ff;
   tmr_ps_s nxt_st;
   logic [7:0] mask;

   // one counter serves both sides, division mask from rate
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.out = 1'b0;
      mask = 8'hFF;
      if (to_wdt)
      begin
         mask = 8'(({1'b0, 8'h00} | 9'h001) << rate) - 8'h01;
      end
      else
      begin
         mask = 8'((9'h002 << rate) - 9'h001);
      end
      if (clr)
      begin
         nxt_st.cnt = 8'h00;
      end
      else if (tick)
      begin
         nxt_st.cnt = st_ff.cnt + 8'h01;
         if ((st_ff.cnt & mask) == mask)
         begin
            nxt_st.out = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign out_tick = st_ff.out;
endmodule

// >>> tmr_timer0.sv
// timer0 with shared prescaler, watchdog count and avalon register slave
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module tmr_timer0
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // count pin and watchdog tick
   input wire logic timer_count_input,
   input wire logic wdt_base_tick,
   // outputs
   output logic wdt_timeout,
   output logic irq
);
   import tmr_pkg::*;

   typedef struct packed {
      logic [1:0] sync;
      logic pin_q;
      logic [1:0] phase;
      logic [7:0] timer_count;
      logic [7:0] option_control;
      logic [7:0] interrupt_control;
      logic [15:0] wdt_cnt;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic [31:0] rdata;
      logic ack;
      logic wdt_to;
      logic irq;
   } tmr_st_s;

   tmr_st_s st_ff;
   tmr_st_s nxt_st;
   logic ps_out;
   logic ps_clr;
   logic ps_tick;
   logic src_edge;
   logic sample;
   logic to_wdt;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wb;
   logic [1:0] ev;

   assign to_wdt = st_ff.option_control[TMR_OPT_PSA];
   assign acc = (avs_read | avs_write) & ~st_ff.ack;
   assign wr = avs_write & ~st_ff.ack;
   assign rd = avs_read & ~st_ff.ack;
   assign wb = avs_writedata[7:0];

   // pin sampled on phases two and four, edge chosen by edge select
   always_comb
   begin
      sample = st_ff.phase[0];
      src_edge = 1'b0;
      if (st_ff.option_control[TMR_OPT_SE])
      begin
         src_edge = st_ff.pin_q & ~st_ff.sync[1];
      end
      else
      begin
         src_edge = ~st_ff.pin_q & st_ff.sync[1];
      end
      src_edge = src_edge & sample;
      if (st_ff.option_control[TMR_OPT_CS])
      begin
         ps_tick = to_wdt ? wdt_base_tick : src_edge;
      end
      else
      begin
         ps_tick = to_wdt ? wdt_base_tick : (st_ff.phase == TMR_PHASE_LAST);
      end
   end

   // clear sources of the shared prescaler
   always_comb
   begin
      ps_clr = 1'b0;
      if (!to_wdt && wr && avs_address == TMR_ADDR_CNT)
      begin
         ps_clr = 1'b1;
      end
      if (to_wdt && wr && avs_address == TMR_ADDR_WDT_CLR)
      begin
         ps_clr = 1'b1;
      end
   end

   // shared prescaler, ratio may change any cycle
   tmr_prescaler u_ps
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clr(ps_clr),
      .tick(ps_tick),
      .rate(st_ff.option_control[TMR_OPT_PS_LO +: 3]),
      .to_wdt(to_wdt),
      .out_tick(ps_out)
   );

   // next state: counter, watchdog, registers, bus
   always_comb
   begin
      nxt_st = st_ff;
      ev = 2'b00;
      nxt_st.sync = {st_ff.sync[0], timer_count_input};
      nxt_st.phase = st_ff.phase + 2'h1;
      if (sample)
      begin
         nxt_st.pin_q = st_ff.sync[1];
      end
      // timer count: prescaler output, or the pin or internal clock directly
      if (!to_wdt && ps_out)
      begin
         nxt_st.timer_count = st_ff.timer_count + 8'h01;
         if (st_ff.timer_count == 8'hFF)
         begin
            ev[TMR_IRQ_OVF] = 1'b1;
         end
      end
      else if (to_wdt && (st_ff.option_control[TMR_OPT_CS] ? src_edge : (st_ff.phase == TMR_PHASE_LAST)))
      begin
         nxt_st.timer_count = st_ff.timer_count + 8'h01;
         if (st_ff.timer_count == 8'hFF)
         begin
            ev[TMR_IRQ_OVF] = 1'b1;
         end
      end
      // watchdog counts its base tick, postscaled only when the prescaler is assigned to it
      nxt_st.wdt_to = 1'b0;
      if (to_wdt ? ps_out : wdt_base_tick)
      begin
         nxt_st.wdt_cnt = st_ff.wdt_cnt + 16'h0001;
         if (st_ff.wdt_cnt == TMR_WDT_MAX)
         begin
            nxt_st.wdt_to = 1'b1;
            ev[TMR_IRQ_WDT] = 1'b1;
         end
      end
      // register writes
      if (wr)
      begin
         case (avs_address)
            TMR_ADDR_CNT: nxt_st.timer_count = wb;
            TMR_ADDR_OPT: nxt_st.option_control = wb;
            TMR_ADDR_ICTL: nxt_st.interrupt_control = wb;
            TMR_ADDR_WDT_CLR: nxt_st.wdt_cnt = '0;
            TMR_ADDR_IRQ_EN: nxt_st.irq_en = wb[1:0];
            TMR_ADDR_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~wb[1:0];
            default: nxt_st.irq_en = st_ff.irq_en;
         endcase
      end
      // set wins over clear
      if (ev[TMR_IRQ_OVF])
      begin
         nxt_st.interrupt_control[TMR_ICTL_OVF] = 1'b1;
      end
      nxt_st.irq_stat = nxt_st.irq_stat | ev;
      // read answer; prescaler count never exposed
      nxt_st.rdata = '0;
      if (rd)
      begin
         case (avs_address)
            TMR_ADDR_CNT: nxt_st.rdata = {24'h0, st_ff.timer_count};
            TMR_ADDR_OPT: nxt_st.rdata = {24'h0, st_ff.option_control};
            TMR_ADDR_ICTL: nxt_st.rdata = {24'h0, st_ff.interrupt_control};
            TMR_ADDR_IRQ_STAT: nxt_st.rdata = {30'h0, st_ff.irq_stat};
            TMR_ADDR_IRQ_EN: nxt_st.rdata = {30'h0, st_ff.irq_en};
            default: nxt_st.rdata = '0;
         endcase
      end
      nxt_st.ack = acc;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         st_ff.option_control <= TMR_OPT_RST;
         st_ff.interrupt_control <= TMR_ICTL_RST;
         st_ff.timer_count <= TMR_CNT_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = ~st_ff.ack;
   assign wdt_timeout = st_ff.wdt_to;
   assign irq = st_ff.irq;
endmodule

// >>> tmr_clk_src.sv
// behavioural clock source on the timer count pin
`timescale 1ns/1ps
module tmr_clk_src
#(
   parameter int HOLD = 4
)
(
   // clock
   input wire logic sys_clk,
   // count pin
   output logic pin
);
   initial pin = 1'h0;
   // each level held HOLD cycles, pin rests low between bursts
   task automatic pulses(input int n);
      repeat (n)
      begin
         pin <= 1'h1;
         repeat (HOLD) @(posedge sys_clk);
         pin <= 1'h0;
         repeat (HOLD) @(posedge sys_clk);
      end
   endtask
endmodule

// >>> tmr_timer0_properties.sv
// port assertions for the timer0 block
`timescale 1ns/1ps
module tmr_timer0_props
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins
   input wire logic timer_count_input,
   input wire logic wdt_base_tick,
   input wire logic wdt_timeout,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // bus handshake
   property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("access not answered");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   // read data
   property p_idle; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_byte; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("upper read bits set");
   property p_unmap; avs_read && avs_waitrequest && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   // interrupt mask and watchdog pulse
   property p_mask;
      avs_write && avs_waitrequest && avs_address == 5'h14 && avs_writedata[1:0] == 2'h0 |=> ##1 !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("masked irq still high");
   property p_wdt; wdt_timeout |=> !wdt_timeout; endproperty
   a_wdt: assert property (p_wdt) else $error("timeout pulse too long");
   c_irq: cover property ($rose(irq));
   c_wdt: cover property (wdt_timeout);
   c_cnt: cover property (avs_write && avs_address == 5'h00);
endmodule
bind tmr_timer0 tmr_timer0_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .timer_count_input(timer_count_input), .wdt_base_tick(wdt_base_tick),
   .wdt_timeout(wdt_timeout), .irq(irq));

// >>> tmr_timer0_tb_top.sv
// testbench for the timer0 block with shared prescaler
`timescale 1ns/1ps
module tmr_timer0_tb_top;
   import tmr_pkg::*;
   logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, pin, wdt_base_tick, wdt_run, wdt_timeout, irq;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   // sticky record of a watchdog timeout pulse
   logic wdt_seen = 1'h0;
   int err_count, n_compared;
   // clock
   initial
   begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // design and far-side source
   tmr_timer0 i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer_count_input(pin), .wdt_base_tick(wdt_base_tick),
      .wdt_timeout(wdt_timeout), .irq(irq));
   tmr_clk_src #(.HOLD(4)) i_src (.sys_clk(sys_clk), .pin(pin));
   // watchdog base tick every cycle while running
   always @(posedge sys_clk) wdt_base_tick <= wdt_run;
   always @(posedge sys_clk) if (wdt_timeout) wdt_seen <= 1'h1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access, held until waitrequest low
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'hA5C3E1, d};
      do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(1'h1, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      acc(1'h0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (95000) @(posedge sys_clk);
      err_count++;
      tally_and_finish;
   end
   // main sequence
   initial
   begin
      {rst_n, avs_read, avs_write, wdt_run} = 4'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd(TMR_ADDR_OPT, TMR_OPT_RST);
      rd(TMR_ADDR_ICTL, TMR_ICTL_RST);
      rd(TMR_ADDR_CNT, TMR_CNT_RST);
      rd(5'h02, 8'h00);
      // pin straight to counter, prescaler on watchdog
      wr(TMR_ADDR_OPT, 8'h28);
      wr(TMR_ADDR_CNT, 8'h00);
      i_src.pulses(5);
      rd(TMR_ADDR_CNT, 8'h05);
      // falling-edge select, still straight from the pin
      wr(TMR_ADDR_OPT, 8'h38);
      wr(TMR_ADDR_CNT, 8'h00);
      i_src.pulses(3);
      rd(TMR_ADDR_CNT, 8'h03);
      // internal clock, one count per four cycles over forty edges
      wr(TMR_ADDR_OPT, 8'h08);
      wr(TMR_ADDR_CNT, 8'h00);
      repeat (38) @(posedge sys_clk);
      rd(TMR_ADDR_CNT, 8'h0A);
      // clear watchdog and prescaler; the prescaler moves to the timer in the rate loop
      wr(TMR_ADDR_WDT_CLR, 8'h00);
      // every timer-side rate, one pulse short of two counts
      for (int r = 0; r < 8; r++)
      begin
         wr(TMR_ADDR_OPT, 8'h20 | 8'(r));
         wr(TMR_ADDR_CNT, 8'h00);
         i_src.pulses(2 * (2 << r) - 1);
         rd(TMR_ADDR_CNT, 8'h01);
      end
      // count write clears a part-filled prescaler
      wr(TMR_ADDR_OPT, 8'h21);
      i_src.pulses(3);
      wr(TMR_ADDR_CNT, 8'h10);
      i_src.pulses(3);
      rd(TMR_ADDR_CNT, 8'h10);
      i_src.pulses(1);
      rd(TMR_ADDR_CNT, 8'h11);
      // move prescaler from timer to watchdog, final rate 111
      wr(TMR_ADDR_WDT_CLR, 8'h00);
      wr(TMR_ADDR_CNT, 8'h00);
      wr(TMR_ADDR_OPT, 8'h2F);
      wr(TMR_ADDR_WDT_CLR, 8'h00);
      // rollover flag, mask and clear
      wr(TMR_ADDR_OPT, 8'h28);
      wr(TMR_ADDR_CNT, 8'hFF);
      wr(TMR_ADDR_IRQ_EN, 8'h01);
      i_src.pulses(1);
      rd(TMR_ADDR_CNT, 8'h00);
      rd(TMR_ADDR_ICTL, 8'h04);
      rd(TMR_ADDR_IRQ_STAT, 8'h01);
      chk({31'h0, irq}, 32'h1);
      wr(TMR_ADDR_IRQ_EN, 8'h00);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      wr(TMR_ADDR_IRQ_EN, 8'h01);
      wr(TMR_ADDR_IRQ_CLR, 8'h01);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      rd(TMR_ADDR_IRQ_STAT, 8'h00);
      rd(TMR_ADDR_ICTL, 8'h04);
      wr(TMR_ADDR_ICTL, 8'h00);
      rd(TMR_ADDR_ICTL, 8'h00);
      // watchdog clear restarts the count, wrap follows later
      wr(TMR_ADDR_WDT_CLR, 8'h00);
      wdt_run <= 1'h1;
      repeat (300) @(posedge sys_clk);
      wr(TMR_ADDR_WDT_CLR, 8'h00);
      repeat (65400) @(posedge sys_clk);
      rd(TMR_ADDR_IRQ_STAT, 8'h00);
      chk({31'h0, wdt_seen}, 32'h0);
      repeat (300) @(posedge sys_clk);
      rd(TMR_ADDR_IRQ_STAT, 8'h02);
      chk({31'h0, wdt_seen}, 32'h1);
      wdt_run <= 1'h0;
      // reset in mid-run brings registers back to their reset values
      @(posedge sys_clk);
      rst_n <= 1'h0;
      @(posedge sys_clk);
      rst_n <= 1'h1;
      rd(TMR_ADDR_OPT, TMR_OPT_RST);
      rd(TMR_ADDR_IRQ_STAT, 8'h00);
      rd(TMR_ADDR_CNT, TMR_CNT_RST);
      chk({31'h0, irq}, 32'h0);
      tally_and_finish;
   end
endmodule
